// ===== design/adcs_pkg.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// shared constants of the converter control and readout port
// ----------------------------------------------------------------
package adcs_pkg;
    // three-level strap pins arrive already resolved to two bits
    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_FLOAT = 2'b01,
        LVL_HIGH  = 2'b10
    } adcs_lvl_e;

    // operating setting reported on op_mode
    typedef enum logic [1:0] {
        OPM_HS = 2'b00,
        OPM_HR = 2'b01,
        OPM_LP = 2'b10
    } adcs_opm_e;

    localparam int          WORD_W      = 24;
    localparam int          SAMPLE_W    = WORD_W + 1;
    localparam int          CNT_W       = 10;
    localparam int          FRM_W       = 11;
    localparam int          MDIV_W      = 3;
    localparam int          BUF_DEPTH   = 2;
    // conversion periods and frame-length threshold in master clocks
    localparam int          CONV_HS     = 256;
    localparam int          CONV_LONG   = 512;
    localparam int          FRAME_SPLIT = 384;
    // modulator clock dividers
    localparam int          MOD_DIV_FAST = 4;
    localparam int          MOD_DIV_LP   = 8;
    // full-scale codes
    localparam logic [23:0] FS_POS      = 24'h7FFFFF;
    localparam logic [23:0] FS_NEG      = 24'h800000;
endpackage

// ----------------------------------------------------------------
// small result buffer between the filter and the serial port
// ----------------------------------------------------------------
module adcs_buf #(
    parameter int W     = 24,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,       // master clock
    input  wire logic         rst_n,     // synchronised reset, active low
    input  wire logic [W-1:0] in_data,   // word from the filter
    input  wire logic         in_valid,  // filter offers a word
    output logic              in_ready,  // buffer can take a word
    output logic      [W-1:0] out_data,  // oldest stored word
    output logic              out_valid, // a word is stored
    input  wire logic         out_ready  // consumer takes the word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;

    // handshake decode
    wire           push     = in_valid && in_ready;
    wire           pop      = out_valid && out_ready;
    wire [CW-1:0]  next_cnt = cnt + CW'(push) - CW'(pop);
    wire [PW-1:0]  next_wp  = (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
    wire [PW-1:0]  next_rp  = (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);

    assign out_data  = mem[rp];
    assign out_valid = cnt != '0;

    // pointers, fill level and a registered ready so a full buffer stalls the filter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp       <= '0;
            rp       <= '0;
            cnt      <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            wp       <= push ? next_wp : wp;
            rp       <= pop ? next_rp : rp;
            cnt      <= next_cnt;
            in_ready <= next_cnt != CW'(DEPTH);
        end
    end

    // storage needs no reset, out_valid guards it
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp] <= in_data;
    end
endmodule

// ===== design/adcs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - mode pin picks speed, resolution or power
// - format pin picks SPI, frame-sync or modulator
// - sync/power-down input is active low
// - chain input cascades converters onto one line
// - data out carries results or modulator bits
// - handshake pin: ready output or frame input
// - serial clock input, output in modulator mode
// - SPI conversion every 256 or 512 clocks
// - ready goes low when result available
// - ready returns high once shifting starts
// - new bit launched on falling serial edge
// - chain bit captured on falling serial edge
// - frame length 256, or auto-detected 256/512
// - results are 24-bit two's complement, clamped
module adcs_top
    import adcs_pkg::*;
#(
    parameter bit MOD_VARIANT = 1'b1
) (
    input  wire logic                mclk,             // master clock
    input  wire logic                nrst,             // reset, active low
    input  wire logic                sclk,             // serial clock from reader
    input  wire logic [1:0]          mode_pin,         // resolved three-level mode strap
    input  wire logic [1:0]          format_pin,       // resolved three-level format strap
    input  wire logic                sync_powerdown_n, // sync / power-down, active low
    input  wire logic                chain_in,         // chain data from next device
    input  wire logic                frame_strobe,     // handshake pin input side
    input  wire logic                mod_bit,          // raw modulator bit
    input  wire logic [SAMPLE_W-1:0] sample_data,      // filter result, one guard bit
    input  wire logic                sample_valid,     // filter offers a result
    output logic                     sample_ready,     // buffer accepts a result
    output logic                     data_out,         // serial result bit
    output logic                     data_out_mod,     // modulator bit for the data pin
    output logic                     data_out_mod_sel, // pin shows data_out_mod
    output logic                     result_ready_n,   // handshake pin output side
    output logic                     handshake_oe,     // handshake pin driven
    output logic                     sclk_o,           // modulator clock out
    output logic                     sclk_oe,          // serial clock pin driven
    output logic [1:0]               op_mode,          // current operating setting
    output logic                     frame_long,       // 512-clock frames detected
    output logic                     conv_halted       // conversion held by sync pin
);
    localparam int PIN_W = 7;

    // ----------------------------------------------------------------
    // reset release in both domains
    // ----------------------------------------------------------------
    logic [1:0] rst_m;
    logic [1:0] rst_l;
    wire        rst_n_m = rst_m[1];
    wire        rst_n_l = rst_l[1];

    // master domain copy of the reset
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rst_m <= '0;
        else
            rst_m <= {rst_m[0], 1'b1};
    end

    // link domain copy; the serial clock may stand, so release waits for edges
    always_ff @(negedge sclk or negedge nrst)
    begin
        if (!nrst)
            rst_l <= '0;
        else
            rst_l <= {rst_l[0], 1'b1};
    end

    // ----------------------------------------------------------------
    // pin synchronisers and strap decode
    // ----------------------------------------------------------------
    logic             ack_tgl;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [1:0]       mode_s;
    logic [1:0]       fmt_s;
    logic             run;
    logic             fs_s;
    logic             ack_s;

    // mode, format, sync and strobe pin levels pass two flops before use
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end
        else
        begin
            pin_s1 <= {ack_tgl, frame_strobe, sync_powerdown_n, format_pin, mode_pin};
            pin_s2 <= pin_s1;
        end
    end

    assign {ack_s, fs_s, run, fmt_s, mode_s} = pin_s2;

    // strap decode
    wire op_hs   = mode_s == LVL_LOW;
    wire op_lp   = mode_s == LVL_HIGH;
    wire fmt_fs  = fmt_s == LVL_HIGH;
    wire fmt_mod = MOD_VARIANT && (fmt_s == LVL_FLOAT);
    wire fmt_spi = !fmt_fs && !fmt_mod;

    // ----------------------------------------------------------------
    // conversion pacing and frame length detection
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] conv_cnt;
    logic [FRM_W-1:0] frame_cnt;
    logic             fs_q;
    logic             send_tgl;
    logic [WORD_W-1:0] word_hold;
    logic             buf_valid;
    logic [WORD_W-1:0] buf_data;

    wire [CNT_W-1:0] conv_last = op_hs ? CNT_W'(CONV_HS - 1) : CNT_W'(CONV_LONG - 1);
    wire             tick_spi  = fmt_spi && run && (conv_cnt == conv_last);
    wire             fs_rise   = fs_s && !fs_q;
    wire             tick_fs   = fmt_fs && run && fs_rise;
    wire             busy      = send_tgl != ack_s;
    wire             take      = (tick_spi || tick_fs) && buf_valid && !busy;
    wire [CNT_W-1:0] next_conv = (!run || conv_cnt >= conv_last) ? '0 : conv_cnt + CNT_W'(1);
    wire             frm_top   = frame_cnt == {FRM_W{1'b1}};
    wire [FRM_W-1:0] next_frame = fs_rise ? '0 : (frm_top ? frame_cnt : frame_cnt + FRM_W'(1));
    wire             long_seen = (frame_cnt >= FRM_W'(FRAME_SPLIT)) && !op_hs;

    // conversion timer restarts whenever the sync pin is held low
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            conv_cnt  <= '0;
            frame_cnt <= '0;
            fs_q      <= 1'b0;
        end
        else
        begin
            conv_cnt  <= next_conv;
            frame_cnt <= next_frame;
            fs_q      <= fs_s;
        end
    end

    // frame length is measured on each strobe rise in frame-sync format; high speed is always short
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
            frame_long <= 1'b0;
        else if (fs_rise && fmt_fs)
            frame_long <= long_seen;
        else if (op_hs)
            frame_long <= 1'b0;
    end

    // ----------------------------------------------------------------
    // result path: clamp, buffer, hand-off word
    // ----------------------------------------------------------------
    wire pos_ovf = !sample_data[SAMPLE_W-1] && sample_data[WORD_W-1];
    wire neg_ovf = sample_data[SAMPLE_W-1] && !sample_data[WORD_W-1];
    wire [WORD_W-1:0] clamped = pos_ovf ? FS_POS :
                                neg_ovf ? FS_NEG : sample_data[WORD_W-1:0];

    adcs_buf #(
        .W     (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (mclk),
        .rst_n     (rst_n_m),
        .in_data   (clamped),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (take)
    );

    // word stays frozen while the toggle is outstanding, so the link may read it
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            send_tgl  <= 1'b0;
            word_hold <= '0;
        end
        else if (take)
        begin
            send_tgl  <= !send_tgl;
            word_hold <= buf_data;
        end
    end

    // ----------------------------------------------------------------
    // handshake pin, status and modulator clock
    // ----------------------------------------------------------------
    logic [MDIV_W-1:0] mod_div;

    wire next_rdy_n = (take && fmt_spi) ? 1'b0 :
                      (!busy || !fmt_spi) ? 1'b1 : result_ready_n;
    wire [MDIV_W-1:0] div_last = op_lp ? MDIV_W'(MOD_DIV_LP - 1) : MDIV_W'(MOD_DIV_FAST - 1);
    wire [MDIV_W-1:0] div_half = op_lp ? MDIV_W'(MOD_DIV_LP / 2) : MDIV_W'(MOD_DIV_FAST / 2);
    wire [MDIV_W-1:0] next_div = (!fmt_mod || mod_div >= div_last) ? '0 : mod_div + MDIV_W'(1);
    wire              mod_fall = fmt_mod && (next_div == div_half);
    wire [1:0]        next_opm = op_hs ? OPM_HS : (op_lp ? OPM_LP : OPM_HR);

    // ready falls with the hand-off, rises once the link took the word
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            result_ready_n <= 1'b1;
            handshake_oe   <= 1'b0;
            op_mode        <= OPM_HS;
            conv_halted    <= 1'b1;
        end
        else
        begin
            result_ready_n <= next_rdy_n;
            handshake_oe   <= fmt_spi;
            op_mode        <= next_opm;
            conv_halted    <= !run;
        end
    end

    // modulator clock is derived here, so it is no second domain
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            mod_div          <= '0;
            sclk_o           <= 1'b0;
            sclk_oe          <= 1'b0;
            data_out_mod     <= 1'b0;
            data_out_mod_sel <= 1'b0;
        end
        else
        begin
            mod_div          <= next_div;
            sclk_o           <= fmt_mod && (next_div < div_half);
            sclk_oe          <= fmt_mod;
            data_out_mod     <= mod_fall ? mod_bit : data_out_mod;
            data_out_mod_sel <= fmt_mod;
        end
    end

    // ----------------------------------------------------------------
    // link domain: shifter on the falling serial edge
    // ----------------------------------------------------------------
    logic [1:0]        req_l;
    logic [WORD_W-1:0] shreg;
    wire               load = req_l[1] != ack_tgl;

    // toggle crossing in, acknowledge toggle back out
    always_ff @(negedge sclk or negedge rst_n_l)
    begin
        if (!rst_n_l)
        begin
            req_l   <= '0;
            ack_tgl <= 1'b0;
        end
        else
        begin
            req_l   <= {req_l[0], send_tgl};
            ack_tgl <= req_l[1];
        end
    end

    // msb first, then the chain input trails behind the word
    always_ff @(negedge sclk or negedge rst_n_l)
    begin
        if (!rst_n_l)
        begin
            data_out <= 1'b0;
            shreg    <= '0;
        end
        else if (load)
        begin
            data_out <= word_hold[WORD_W-1];
            shreg    <= {word_hold[WORD_W-2:0], chain_in};
        end
        else
        begin
            data_out <= shreg[WORD_W-1];
            shreg    <= {shreg[WORD_W-2:0], chain_in};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] gap_cnt;
    logic             gap_ok;
    logic             prev_hs;

    // measures distance between conversions while the setting holds still
    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            gap_cnt <= '0;
            gap_ok  <= 1'b0;
            prev_hs <= 1'b0;
        end
        else
        begin
            prev_hs <= op_hs;
            gap_cnt <= tick_spi ? '0 : gap_cnt + CNT_W'(1);
            gap_ok  <= tick_spi ? 1'b1 : (gap_ok && run && fmt_spi && op_hs == prev_hs);
        end
    end

    AST_MODE_DECODE: assert property (@(posedge mclk) disable iff (!rst_n_m)
        (mode_s == LVL_LOW) |=> (op_mode == OPM_HS))
        else $error("mode pin low did not give high-speed setting");
    AST_FMT_OE: assert property (@(posedge mclk) disable iff (!rst_n_m)
        fmt_fs |=> !handshake_oe)
        else $error("handshake pin driven in frame-sync format");
    AST_SYNC_HOLD: assert property (@(posedge mclk) disable iff (!rst_n_m)
        !run |-> ##1 (conv_cnt == '0) && !take)
        else $error("conversion advanced while sync pin low");
    AST_SCLK_DIR: assert property (@(posedge mclk) disable iff (!rst_n_m)
        !fmt_mod |=> !sclk_oe && !sclk_o)
        else $error("serial clock driven outside modulator format");
    AST_SPI_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n_m)
        (tick_spi && gap_ok) |-> (gap_cnt == conv_last))
        else $error("conversion spacing wrong");
    AST_RDY_FALL: assert property (@(posedge mclk) disable iff (!rst_n_m)
        (take && fmt_spi) |=> !result_ready_n ##1 (busy || result_ready_n))
        else $error("ready did not fall with new result");
    AST_RDY_RISE: assert property (@(posedge mclk) disable iff (!rst_n_m)
        (!result_ready_n && !busy && !take && fmt_spi) |=> result_ready_n)
        else $error("ready stayed low after word was taken");
    AST_FRAME_LEN: assert property (@(posedge mclk) disable iff (!rst_n_m)
        (fs_rise && fmt_fs && long_seen) |=> frame_long)
        else $error("long frame not detected");
    AST_CLAMP: assert property (@(posedge mclk) disable iff (!rst_n_m)
        pos_ovf |-> (clamped == FS_POS))
        else $error("positive overflow not clamped to full scale");
    AST_SHIFT_ORDER: assert property (@(negedge sclk) disable iff (!rst_n_l)
        (load ##1 !load) |=> (data_out == $past(word_hold[WORD_W-2], 2)))
        else $error("second result bit not shifted after msb");
    AST_CHAIN_CAPTURE: assert property (@(negedge sclk) disable iff (!rst_n_l)
        rst_n_l |=> (shreg[0] == $past(chain_in)))
        else $error("chain bit not captured on falling edge");

    COV_SPI_TAKE: cover property (@(posedge mclk) disable iff (!rst_n_m)
        take && fmt_spi);
    COV_FS_TAKE: cover property (@(posedge mclk) disable iff (!rst_n_m)
        take && fmt_fs);
    COV_LONG_FRAME: cover property (@(posedge mclk) disable iff (!rst_n_m)
        $rose(frame_long));
    COV_BUF_FULL: cover property (@(posedge mclk) disable iff (!rst_n_m)
        !sample_ready && sample_valid);
endmodule

// ===== dv/adcs_reader.sv
`timescale 1ns/1ps
// ----------------------------------------
// readout controller on the far side
// ----------------------------------------
module adcs_reader (
    input  wire logic        mclk,         // master clock
    input  wire logic        fs_en,        // frame-sync use
    input  wire logic [10:0] frame_len,    // frame length in mclk
    input  wire logic        data_pin,     // device data pin
    input  wire logic        hs_pin,       // handshake pin
    output logic             sclk_drv,     // serial clock
    output logic             chain_drv,    // chain data
    output logic             strobe_drv,   // frame strobe
    output logic [23:0]      rx_word,      // last word read
    output logic [7:0]       rx_chain,     // chained bits read
    output logic [7:0]       rx_chain_exp, // chained bits sent
    output int               rx_count      // words read
);
    logic [10:0] fcnt;
    logic [4:0]  ccnt;
    logic [24:0] hist;
    int          i;

    // serial clock runs free: the link reset only releases while it runs
    initial
    begin
        ccnt = 5'h0;
        chain_drv = 1'b0;
        fcnt = 11'h0;
        strobe_drv = 1'b0;
        hist = 25'h0;
        rx_count = 0;
        sclk_drv = 1'b0;
        #17;
        // deliberately not a power-of-two fraction of mclk, to stress the crossing
        forever #62.5 sclk_drv = ~sclk_drv;
    end

    // chain bit changes on rising edges, so it is steady at the falling one
    always @(posedge sclk_drv)
    begin
        ccnt <= ccnt + 5'h1;
        chain_drv <= ccnt[0] ^ ccnt[2];
    end

    // bits the device captured, newest in bit 0
    always @(negedge sclk_drv)
        hist <= {hist[23:0], chain_drv};

    // strobe high for half a frame; released it toggles so it shows no level
    always @(posedge mclk)
    begin
        fcnt <= (fcnt >= frame_len - 11'h1) ? 11'h0 : fcnt + 11'h1;
        strobe_drv <= fs_en ? (fcnt < (frame_len >> 1)) : ~strobe_drv;
    end

    // read a word and eight chained bits once ready is given back
    initial
    forever
    begin
        @(posedge hs_pin);
        if (!fs_en)
        begin
            for (i = 0; i < 32; i++)
            begin
                @(posedge sclk_drv);
                if (i < 24)
                    rx_word[23 - i] = data_pin;
                else
                begin
                    rx_chain[i - 24] = data_pin;
                    rx_chain_exp[i - 24] = hist[24];
                end
            end
            rx_count++;
        end
    end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// converter port bench
// ----------------------------------------
module testbench
import adcs_pkg::*;
;
    logic        mclk, nrst, sync_n, mod_bit, sample_valid, fs_en;
    logic [1:0]  mode_pin, format_pin;
    logic [24:0] sample_data;
    logic [10:0] frame_len;
    wire         sample_ready, data_out, data_out_mod, mod_sel, rdy_n, hs_oe;
    wire         sclk_o, sclk_oe, frame_long, halted, rd_sclk, rd_chain, rd_strobe;
    wire  [1:0]  op_mode;
    wire  [23:0] rx_word;
    wire  [7:0]  rx_chain, rx_exp;
    int          rx_count, miscompares, total_checks, cyc;
    int          falls[$];
    logic        prev_rdy = 1'b1;
    logic [1:0]  mexp[4] = '{OPM_HS, OPM_HR, OPM_LP, OPM_HR};
    logic [1:0]  fmts[3] = '{2'h0, 2'h2, 2'h1};
    logic [24:0] words[6] = '{25'h0123456, 25'h1FEDCBA, 25'h0800000,
                              25'h17FFFFF, 25'h07FFFFF, 25'h1800000};
    // shared pins resolved from the enables
    wire         sclk_pin = sclk_oe ? sclk_o : rd_sclk;
    wire         hs_pin   = hs_oe ? rdy_n : rd_strobe;
    wire         data_pin = mod_sel ? data_out_mod : data_out;

    adcs_top dut_u (.mclk(mclk), .nrst(nrst), .sclk(sclk_pin),
        .mode_pin(mode_pin), .format_pin(format_pin), .sync_powerdown_n(sync_n),
        .chain_in(rd_chain), .frame_strobe(hs_pin), .mod_bit(mod_bit),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .data_out(data_out), .data_out_mod(data_out_mod),
        .data_out_mod_sel(mod_sel), .result_ready_n(rdy_n), .handshake_oe(hs_oe),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .op_mode(op_mode),
        .frame_long(frame_long), .conv_halted(halted));

    adcs_reader rdr_u (.mclk(mclk), .fs_en(fs_en), .frame_len(frame_len),
        .data_pin(data_pin), .hs_pin(hs_pin), .sclk_drv(rd_sclk), .chain_drv(rd_chain),
        .strobe_drv(rd_strobe), .rx_word(rx_word), .rx_chain(rx_chain),
        .rx_chain_exp(rx_exp), .rx_count(rx_count));

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    // ready falls logged on the quiet edge, away from its update
    always @(negedge mclk)
    begin
        cyc++;
        if (prev_rdy === 1'b1 && rdy_n === 1'b0)
            falls.push_back(cyc);
        prev_rdy = rdy_n;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic do_reset(input logic [1:0] m, input logic [1:0] f);
        nrst = 1'b0;
        mode_pin = m;
        format_pin = f;
        tick(6);
        check("halt_rst", halted, 1'b1);
        nrst = 1'b1;
        tick(80);
    endtask

    function automatic logic [23:0] clamp(input logic [24:0] w);
        if ($signed(w) > $signed(25'h07FFFFF))
            return FS_POS;
        if ($signed(w) < $signed(25'h1800000))
            return FS_NEG;
        return w[23:0];
    endfunction

    // offer a word and hold it until the buffer takes it
    task automatic push(input logic [24:0] w);
        int n;
        sample_data = w;
        sample_valid = 1'b1;
        n = 0;
        while (sample_ready !== 1'b1 && n < 4000)
        begin
            tick(1);
            n++;
        end
        if (n >= 4000)
            miscompares++;
        tick(1);
    endtask

    task automatic read_word(input logic [24:0] w);
        int c0;
        int n;
        c0 = rx_count;
        push(w);
        sample_valid = 1'b0;
        n = 0;
        while (rx_count == c0 && n < 4000)
        begin
            tick(1);
            n++;
        end
        check("ready_cycle", rx_count != c0, 1'b1);
        check("word", rx_word, clamp(w));
        check("chain", rx_chain, rx_exp);
    endtask

    // two words wait while halted, a third is refused, then pacing is timed
    task automatic interval(input logic [1:0] m, input int exp);
        int n;
        sync_n = 1'b0;
        do_reset(m, 2'h0);
        push(25'h0000001);
        push(25'h0000002);
        sample_data = 25'h0000003;
        tick(4);
        check("full", sample_ready, 1'b0);
        check("halted", halted, 1'b1);
        sample_valid = 1'b0;
        falls.delete();
        sync_n = 1'b1;
        n = 0;
        while (falls.size() < 2 && n < 3000)
        begin
            tick(1);
            n++;
        end
        check("running", halted, 1'b0);
        check("period", falls[1] - falls[0], exp);
    endtask

    task automatic mod_period(input int exp);
        longint t0;
        @(posedge sclk_o);
        t0 = $time;
        @(posedge sclk_o);
        check("mod_clk", ($time - t0) / 5, exp);
        tick(1);
    endtask

    // main sequence
    initial
    begin
        nrst = 1'b0;
        sync_n = 1'b1;
        mod_bit = 1'b0;
        sample_valid = 1'b0;
        sample_data = 25'h0;
        fs_en = 1'b1;
        frame_len = 11'h200;
        do_reset(2'h0, 2'h0);
        for (int k = 0; k < 4; k++)
        begin
            mode_pin = k[1:0];
            tick(8);
            check("op_mode", op_mode, mexp[k]);
        end
        for (int k = 0; k < 3; k++)
        begin
            format_pin = fmts[k];
            tick(8);
            check("hs_oe", hs_oe, k == 0);
            check("sclk_oe", sclk_oe, k == 2);
            check("mod_sel", mod_sel, k == 2);
        end
        fs_en = 1'b0;
        do_reset(2'h0, 2'h0);
        tick(1400);
        foreach (words[k])
            read_word(words[k]);
        interval(2'h0, CONV_HS);
        interval(2'h1, CONV_LONG);
        fs_en = 1'b1;
        do_reset(2'h1, 2'h2);
        // two stored words leave the buffer only on frame strobe rises
        push(25'h0000ABC);
        push(25'h1FFF000);
        sample_valid = 1'b0;
        tick(2200);
        check("long", frame_long, 1'b1);
        check("fs_drain", sample_ready, 1'b1);
        frame_len = 11'h100;
        tick(1200);
        check("short", frame_long, 1'b0);
        do_reset(2'h0, 2'h1);
        mod_period(MOD_DIV_FAST);
        mode_pin = 2'h2;
        tick(8);
        mod_period(MOD_DIV_LP);
        mod_bit = 1'b1;
        tick(20);
        check("mod_hi", data_pin, 1'b1);
        mod_bit = 1'b0;
        tick(20);
        check("mod_lo", data_pin, 1'b0);
        give_verdict();
    end

    // watchdog well beyond the expected run
    initial
    begin
        #400000;
        miscompares++;
        give_verdict();
    end
endmodule
